/* verilog/cdr_top.sv */
// Instruction and data access logic of a character display controller
// Overview of operation
// - Top-bit instruction loads address, selects display RAM
// - Counter steps after display RAM access
// - Forty characters per row, two row ranges
// - Instruction read returns busy plus counter
// - Busy flag set; instructions refused meanwhile
// - One counter shared by both RAMs
// - Data write stores byte in selected RAM
// - Step after write, apply display shift
// - Glyph top three bits stored, not shown
// - Data read returns byte from selected RAM
// - Reads pipelined; second read is valid
// - Cursor shift primes reads like address
// - Counter steps after every data read
// - Read right after write is invalid
// - Step bit one increments, zero decrements
// - Row bit one selects two rows
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ps
`include "cdr_defs.svh"

// ----------------------------------------------------------------
// Update FIFO
// ----------------------------------------------------------------
module cdr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,       // Clock
    input  wire logic             rst_n,     // Sync reset, active low
    input  wire logic             ce,        // Clock enable
    input  wire logic             in_valid,  // Word offered
    output logic                  in_ready,  // Room for a word
    input  wire logic [WIDTH-1:0] in_data,   // Word in
    output logic                  out_valid, // Word available
    input  wire logic             out_ready, // Sink takes word
    output logic      [WIDTH-1:0] out_data   // Word out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (count_r != (AW+1)'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data  = mem_r[rd_ptr_r];
    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else if (ce) begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ----------------------------------------------------------------
// Access engine with Avalon-MM register slave
// ----------------------------------------------------------------
module cdr_top #(
    parameter int EXEC_CYC   = `CDR_EXEC_CYC,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic                 clk,           // 250 MHz clock
    input  wire logic                 rst_n,         // Sync reset, low
    input  wire logic                 ce,            // Clock enable
    input  wire cdr_pkg::cdr_avm_req_s avm_req,      // Avalon request
    output logic                      avm_waitrequest, // Avalon stall
    output logic [31:0]               avm_readdata,  // Avalon read data
    output logic                      upd_valid,     // RAM update ready
    output cdr_pkg::cdr_upd_s         upd_data,      // RAM update word
    input  wire logic                 upd_ready      // Scanner takes it
);
    import cdr_pkg::*;
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]  display_data_ram_r [128];
    logic [7:0]  glyph_pattern_ram_r [64];
    logic [6:0]  address_counter_r;
    logic        glyph_sel_r;
    logic        step_up_r;
    logic        shift_en_r;
    logic        two_row_r;
    logic [5:0]  disp_shift_r;
    logic [7:0]  rd_latch_r;
    logic        rd_valid_r;
    logic        wait_r;
    logic [31:0] rdata_r;
    cdr_state_e  state_r;
    logic [7:0]  cnt_r;
    cdr_upd_s    pend_r;
    logic        fifo_in_ready;

    // ------------------------------------------------------------
    // Address stepping
    // ------------------------------------------------------------
    // Display addresses skip the hole between rows so that the
    // counter never leaves the stored 40-character ranges.
    function automatic logic [6:0] step_addr(
        input logic [6:0] a,
        input logic       glyph,
        input logic       up,
        input logic       rows2
    );
        logic [6:0] n;
        n = up ? a + 7'h01 : a - 7'h01;
        if (glyph) begin
            n = n & `CDR_GLYPH_MASK;
        end else if (up && a == `CDR_ROW0_LAST) begin
            n = rows2 ? `CDR_ROW1_FIRST : `CDR_ROW0_FIRST;
        end else if (up && a == `CDR_ROW1_LAST) begin
            n = `CDR_ROW0_FIRST;
        end else if (!up && a == `CDR_ROW0_FIRST) begin
            n = rows2 ? `CDR_ROW1_LAST : `CDR_ROW0_LAST;
        end else if (!up && a == `CDR_ROW1_FIRST) begin
            n = `CDR_ROW0_LAST;
        end
        return n;
    endfunction

    function automatic logic [5:0] step_shift(
        input logic [5:0] s,
        input logic       left
    );
        logic [5:0] n;
        n = s;
        if (left) begin
            n = (s == 6'(`CDR_ROW_CHARS - 1)) ? 6'h00 : s + 6'h01;
        end else begin
            n = (s == 6'h00) ? 6'(`CDR_ROW_CHARS - 1) : s - 6'h01;
        end
        return n;
    endfunction

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire       req      = avm_req.read || avm_req.write;
    wire       go       = ce && wait_r && req && rst_n;
    wire       lane0    = avm_req.byteenable[0];
    wire [7:0] wbyte    = avm_req.writedata[7:0];
    wire       hit_ins  = (avm_req.address == `CDR_OFS_INSTR);
    wire       hit_dat  = (avm_req.address == `CDR_OFS_DATA);
    wire       hit_mode = (avm_req.address == `CDR_OFS_MODE);
    wire       hit_stat = (avm_req.address == `CDR_OFS_STATUS);
    wire       busy     = (state_r != CDR_IDLE);
    wire       free     = go && !busy;

    // Accesses that start internal work are ignored while busy; mode writes are not
    wire ins_wr  = free && avm_req.write && hit_ins && lane0;
    wire dat_wr  = free && avm_req.write && hit_dat && lane0;
    wire dat_rd  = free && avm_req.read && hit_dat;
    wire mode_wr = go && avm_req.write && hit_mode && lane0;

    wire is_dd_set = wbyte[`CDR_DD_SET_BIT];
    wire is_cg_set = !is_dd_set && wbyte[`CDR_CG_SET_BIT];
    wire is_shift  = wbyte[7:5] == 3'b000 && wbyte[`CDR_SHIFT_BIT];
    wire shift_sc  = wbyte[`CDR_SHIFT_SC_BIT];
    wire shift_rt  = wbyte[`CDR_SHIFT_RL_BIT];

    wire [6:0] ac_step = step_addr(address_counter_r, glyph_sel_r,
                                   step_up_r, two_row_r);
    wire [6:0] ac_shift = step_addr(address_counter_r, 1'b0,
                                    shift_rt, two_row_r);
    wire [7:0] ram_q = glyph_sel_r ?
        glyph_pattern_ram_r[address_counter_r[5:0]] :
        display_data_ram_r[address_counter_r];

    wire [31:0] rd_mux =
        hit_ins  ? {24'h0, busy, address_counter_r} :
        hit_dat  ? {24'h0, rd_latch_r} :
        hit_mode ? {29'h0, two_row_r, shift_en_r, step_up_r} :
        hit_stat ? {22'h0, disp_shift_r, state_r, rd_valid_r,
                    glyph_sel_r} :
        32'h0;

    // ------------------------------------------------------------
    // Avalon answer: one wait cycle, then a one-cycle release
    // ------------------------------------------------------------
    assign avm_waitrequest = wait_r;
    assign avm_readdata    = rdata_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h0;
        end else if (ce) begin
            wait_r  <= !(wait_r && req);
            rdata_r <= (wait_r && avm_req.read) ? rd_mux : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            step_up_r  <= 1'(`CDR_MODE_RESET >> `CDR_MODE_UP_BIT);
            shift_en_r <= 1'b0;
            two_row_r  <= 1'b0;
        end else if (ce && mode_wr) begin
            step_up_r  <= wbyte[`CDR_MODE_UP_BIT];
            shift_en_r <= wbyte[`CDR_MODE_SHIFT_BIT];
            two_row_r  <= wbyte[`CDR_MODE_ROWS_BIT];
        end
    end

    // ------------------------------------------------------------
    // Address counter, RAM select, display shift
    // ------------------------------------------------------------
    // A single counter for both RAMs: it holds what the last
    // instruction or access left in it.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            address_counter_r <= 7'h00;
            glyph_sel_r       <= 1'b0;
            disp_shift_r      <= 6'h00;
        end else if (ce) begin
            if (ins_wr && is_dd_set) begin
                address_counter_r <= wbyte[6:0];
                glyph_sel_r       <= 1'b0;
            end else if (ins_wr && is_cg_set) begin
                address_counter_r <= wbyte[6:0] & `CDR_GLYPH_MASK;
                glyph_sel_r       <= 1'b1;
            end else if (ins_wr && is_shift) begin
                address_counter_r <= ac_shift;
                glyph_sel_r       <= 1'b0;
                if (shift_sc) begin
                    disp_shift_r <= step_shift(disp_shift_r, !shift_rt);
                end
            end else if (dat_wr || dat_rd) begin
                address_counter_r <= ac_step;
                if (dat_wr && shift_en_r && !glyph_sel_r) begin
                    disp_shift_r <= step_shift(disp_shift_r, step_up_r);
                end
            end
        end
    end

    // ------------------------------------------------------------
    // RAM writes
    // ------------------------------------------------------------
    // All eight bits are kept in glyph RAM; the scanner uses only
    // the low five, so the top three read back but never show.
    always_ff @(posedge clk) begin
        if (ce && dat_wr) begin
            if (glyph_sel_r) begin
                glyph_pattern_ram_r[address_counter_r[5:0]] <= wbyte;
            end else begin
                display_data_ram_r[address_counter_r] <= wbyte;
            end
        end
    end

    // ------------------------------------------------------------
    // Read pipeline
    // ------------------------------------------------------------
    // A read returns the latch and refills it from the counter, so
    // the addressed byte only appears on the next read.  A write or
    // an address change leaves the latch stale.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_latch_r <= 8'h00;
            rd_valid_r <= 1'b0;
        end else if (ce) begin
            if (dat_rd) begin
                rd_latch_r <= ram_q;
                rd_valid_r <= 1'b1;
            end else if (dat_wr || ins_wr) begin
                rd_valid_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Busy sequencing and update stream
    // ------------------------------------------------------------
    // A full FIFO holds the engine in PUSH, so busy stretches and
    // the host is throttled through its own polling.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= CDR_IDLE;
            cnt_r   <= 8'h00;
            pend_r  <= '0;
        end else if (ce) begin
            case (state_r)
                CDR_IDLE: begin
                    if (dat_wr) begin
                        state_r <= CDR_PUSH;
                        pend_r  <= '{glyph: glyph_sel_r,
                                     addr:  address_counter_r,
                                     data:  wbyte};
                    end else if (ins_wr || dat_rd) begin
                        state_r <= CDR_EXEC;
                    end
                    cnt_r <= 8'(EXEC_CYC - 1);
                end
                CDR_PUSH: begin
                    if (fifo_in_ready) begin
                        state_r <= CDR_EXEC;
                    end
                end
                CDR_EXEC: begin
                    if (cnt_r == 8'h00) begin
                        state_r <= CDR_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                default: begin
                    state_r <= CDR_IDLE;
                end
            endcase
        end
    end

    logic [15:0] fifo_q;
    assign upd_data = cdr_upd_s'(fifo_q);

    cdr_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_valid  (state_r == CDR_PUSH),
        .in_ready  (fifo_in_ready),
        .in_data   (pend_r),
        .out_valid (upd_valid),
        .out_ready (upd_ready),
        .out_data  (fifo_q)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    a_dd_set_load: assert property (ins_wr && is_dd_set |=>
        address_counter_r == $past(wbyte[6:0]) && !glyph_sel_r)
        else $error("display address set not loaded");
    a_busy_on_access: assert property (ins_wr || dat_wr || dat_rd
        |=> busy) else $error("busy did not rise");
    a_busy_refuse: assert property (go && busy && hit_ins
        && avm_req.write |=> $stable(address_counter_r))
        else $error("instruction accepted while busy");
    a_busy_clears: assert property (dat_rd |=> busy [*1]
        ##[0:20] !busy) else $error("busy never cleared");
    a_instr_read: assert property (go && avm_req.read && hit_ins
        |=> avm_readdata[7] == $past(busy) &&
        avm_readdata[6:0] == $past(address_counter_r))
        else $error("instruction read wrong");
    a_step_up: assert property (dat_rd && step_up_r && !glyph_sel_r
        && address_counter_r == 7'h10 |=> address_counter_r == 7'h11)
        else $error("counter did not increment");
    a_step_down: assert property (dat_wr && !step_up_r
        && address_counter_r == 7'h10 |=> address_counter_r == 7'h0F)
        else $error("counter did not decrement");
    a_row_wrap: assert property (dat_wr && step_up_r && !glyph_sel_r
        && two_row_r && address_counter_r == `CDR_ROW0_LAST
        |=> address_counter_r == `CDR_ROW1_FIRST)
        else $error("row wrap wrong");
    a_read_pipe: assert property (dat_rd && rd_valid_r
        |=> avm_readdata[7:0] == $past(rd_latch_r))
        else $error("read pipeline broken");
    a_write_stale: assert property (dat_wr |=> !rd_valid_r)
        else $error("read latch valid after write");
    a_wait_one: assert property (go |=> !avm_waitrequest ##1
        avm_waitrequest) else $error("bus answer timing wrong");

    c_dd_write: cover property (dat_wr && !glyph_sel_r);
    c_cg_write: cover property (dat_wr && glyph_sel_r);
    c_two_reads: cover property (dat_rd ##[1:40] dat_rd);
    c_fifo_full: cover property (state_r == CDR_PUSH && !fifo_in_ready);
endmodule

/* verilog/cdr_defs.svh */
// Offsets, field positions, reset values and timing counts for cdr_top
`ifndef CDR_DEFS_SVH
`define CDR_DEFS_SVH

// Word offsets on the Avalon-MM slave (byte addresses)
`define CDR_OFS_INSTR      6'h00
`define CDR_OFS_DATA       6'h04
`define CDR_OFS_MODE       6'h08
`define CDR_OFS_STATUS     6'h0C

// Instruction encodings
`define CDR_DD_SET_BIT     7
`define CDR_CG_SET_BIT     6
`define CDR_SHIFT_BIT      4
`define CDR_SHIFT_SC_BIT   3
`define CDR_SHIFT_RL_BIT   2

// Mode register fields
`define CDR_MODE_UP_BIT    0
`define CDR_MODE_SHIFT_BIT 1
`define CDR_MODE_ROWS_BIT  2
`define CDR_MODE_RESET     3'h1

// Display-data layout
`define CDR_ROW_CHARS      40
`define CDR_ROW0_FIRST     7'h00
`define CDR_ROW0_LAST      7'h27
`define CDR_ROW1_FIRST     7'h40
`define CDR_ROW1_LAST      7'h67
`define CDR_GLYPH_MASK     7'h3F

// Internal execution time of one access
`define CDR_EXEC_NS        40
`define CDR_CLK_MHZ        250
`define CDR_EXEC_CYC       ((`CDR_EXEC_NS * `CDR_CLK_MHZ + 999) / 1000)

`endif

/* verilog/cdr_pkg.sv */
// Types shared by the character display access block
package cdr_pkg;

    typedef enum logic [1:0] {
        CDR_IDLE = 2'b00,
        CDR_PUSH = 2'b01,
        CDR_EXEC = 2'b10
    } cdr_state_e;

    typedef struct packed {
        logic       glyph;
        logic [6:0] addr;
        logic [7:0] data;
    } cdr_upd_s;

    typedef struct packed {
        logic [5:0]  address;
        logic        read;
        logic        write;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } cdr_avm_req_s;

endpackage

/* test/cdr_sink.sv */
// Display scanner stand-in: takes update words and keeps shadow RAMs
`timescale 1ns/1ps

module cdr_sink (
    input  wire logic             clk,   // Clock
    input  wire logic             rst_n, // Sync reset, low
    input  wire logic             stall, // Hold ready low
    input  wire logic             slow,  // Take every other cycle
    input  wire logic             valid, // Word offered
    input  wire cdr_pkg::cdr_upd_s word,  // Update word
    output logic                  ready  // Word taken at edge
);
    import cdr_pkg::*;

    logic [7:0] dd [128];
    logic [7:0] cg [64];
    logic       tog_r;

    // Ready only changes just after an edge, like a real scanner
    always @(posedge clk) begin
        tog_r <= rst_n ? !tog_r : 1'b0;
        ready <= rst_n && !stall && (!slow || tog_r);
        if (valid && ready && word.glyph) begin
            cg[word.addr[5:0]] <= word.data;
        end
        if (valid && ready && !word.glyph) begin
            dd[word.addr] <= word.data;
        end
    end
endmodule

/* test/cdr_top_tb_top.sv */
// Self-checking bench for the character display access block
`timescale 1ns/1ps
`include "cdr_defs.svh"

module cdr_top_tb_top;
    import cdr_pkg::*;

    localparam logic [5:0] oi = `CDR_OFS_INSTR;
    localparam logic [5:0] od = `CDR_OFS_DATA;
    localparam logic [5:0] om = `CDR_OFS_MODE;
    localparam logic [5:0] os = `CDR_OFS_STATUS;

    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    cdr_avm_req_s req = '0;
    logic         wreq;
    logic [31:0]  rdat;
    logic         uv;
    cdr_upd_s     ud;
    logic         urdy;
    logic         stall = 1'b0;
    logic         slow = 1'b0;
    logic         ce = 1'b1;
    int           failures = 0;
    int           checks_done = 0;
    logic [31:0]  q;
    logic [6:0]   a;
    logic [7:0]   b;
    int           i;
    logic [2:0]   tm [7] = '{3'h5, 3'h1, 3'h5, 3'h4, 3'h0, 3'h4, 3'h0};
    logic [6:0]   ta [7] = '{7'h27, 7'h27, 7'h67, 7'h00, 7'h00, 7'h40,
                             7'h10};

    // FIFO kept at two words so a stalled scanner fills it quickly
    cdr_top #(.EXEC_CYC(3), .FIFO_DEPTH(2)) i_cdr_top (
        .clk(clk), .rst_n(rst_n), .ce(ce), .avm_req(req),
        .avm_waitrequest(wreq), .avm_readdata(rdat),
        .upd_valid(uv), .upd_data(ud), .upd_ready(urdy));
    cdr_sink i_cdr_sink (
        .clk(clk), .rst_n(rst_n), .stall(stall), .slow(slow),
        .valid(uv), .word(ud), .ready(urdy));

    initial forever #2 clk = ~clk;

    // ------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] got,
                       input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask

    // Holds the request until waitrequest is seen low, then one idle edge
    task automatic bus(input logic w, input logic [5:0] ad,
                       input logic [7:0] d);
        int n;
        n = 0;
        req.address <= ad;
        req.read <= !w;
        req.write <= w;
        req.byteenable <= 4'hF;
        req.writedata <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 64);
        q = rdat;
        req.read <= 1'b0;
        req.write <= 1'b0;
        @(posedge clk);
        if (n >= 64) begin
            failures++;
            conclude();
        end
    endtask

    task automatic wr(input logic [5:0] ad, input logic [7:0] d);
        bus(1'b1, ad, d);
    endtask

    task automatic rd(input logic [5:0] ad);
        bus(1'b0, ad, 8'h00);
    endtask

    // Leaves the last counter read in q with busy clear
    task automatic idle;
        int n;
        for (n = 0; n < 100; n++) begin
            rd(oi);
            if (q[7] === 1'b0) return;
        end
        failures++;
        conclude();
    endtask

    function automatic logic [6:0] nxt(logic [6:0] x, logic up, logic r2);
        if (up && x == 7'h27) return r2 ? 7'h40 : 7'h00;
        if (up && x == 7'h67) return 7'h00;
        if (up) return x + 7'h01;
        if (x == 7'h00) return r2 ? 7'h67 : 7'h27;
        if (x == 7'h40) return 7'h27;
        return x - 7'h01;
    endfunction

    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        conclude();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        i = $urandom(32'hA14F1AA6);
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(om);
        chk("mode", q, 32'h1);
        rd(oi);
        chk("instr", q, 32'h0);
        rd(os);
        chk("status", q, 32'h0);
        rd(6'h10);
        chk("unmapped", q, 32'h0);
        $display("test reset ended");
        wr(oi, 8'hC5);
        rd(oi);
        chk("busy", q[7], 32'h1);
        idle();
        chk("counter", q, 32'h45);
        wr(oi, 8'h80);
        wr(oi, 8'h93);
        idle();
        chk("refused", q, 32'h0);
        $display("test busy ended");
        for (i = 0; i < 7; i++) begin
            wr(om, {5'h0, tm[i]});
            wr(oi, {1'b1, ta[i]});
            idle();
            b = 8'($urandom);
            wr(od, b);
            idle();
            a = nxt(ta[i], tm[i][0], tm[i][2]);
            chk("step", q, {25'h0, a});
            chk("stored", i_cdr_sink.dd[ta[i]], {24'h0, b});
        end
        $display("test stepping ended");
        slow <= 1'b1;
        wr(om, 8'h05);
        for (i = 0; i < 8; i++) begin
            a = ($urandom % 2) ? 7'h40 : 7'h00;
            a = a + 7'($urandom % 40);
            if (i == 0) a = 7'h10;
            b = 8'($urandom);
            wr(oi, {1'b1, a});
            idle();
            wr(od, b);
            idle();
            rd(os);
            chk("latch", q[1], 32'h0);
            wr(oi, {1'b1, a});
            idle();
            rd(od); // first read is stale
            idle();
            rd(od);
            chk("readback", q, {24'h0, b});
            idle();
            chk("read step", q, {25'h0, nxt(nxt(a, 1, 1), 1, 1)});
        end
        wr(oi, 8'h85);
        idle();
        wr(od, 8'h3C);
        idle();
        wr(od, 8'h5A);
        idle();
        wr(oi, 8'h85);
        idle();
        wr(oi, 8'h14);
        idle();
        rd(od);
        idle();
        rd(od);
        chk("shift primes", q, 32'h5A);
        idle();
        $display("test reads ended");
        wr(oi, 8'h7F);
        idle();
        wr(od, 8'hE5);
        idle();
        chk("glyph wrap", q, 32'h0);
        rd(os);
        chk("glyph sel", q[0], 32'h1);
        chk("glyph sink", i_cdr_sink.cg[63], 32'hE5);
        wr(oi, 8'h7F);
        idle();
        rd(od);
        idle();
        rd(od);
        chk("glyph read", q, 32'hE5);
        idle();
        wr(om, 8'h07);
        wr(oi, 8'h80);
        idle();
        wr(od, 8'h41);
        idle();
        rd(os);
        chk("disp shift", q[9:4], 32'h1);
        $display("test glyph ended");
        slow <= 1'b0;
        stall <= 1'b1;
        wr(om, 8'h05);
        wr(oi, 8'h90);
        idle();
        for (i = 0; i < 3; i++) begin
            wr(od, 8'hA0 + 8'(i));
            if (i < 2) idle();
        end
        repeat (8) @(posedge clk);
        chk("held", uv, 32'h1);
        rd(os);
        chk("push wait", q[3:2], 32'h1);
        stall <= 1'b0;
        idle();
        repeat (4) @(posedge clk);
        for (i = 0; i < 3; i++) begin
            chk("drain", i_cdr_sink.dd[7'h10 + 7'(i)], 32'hA0 + i);
        end
        chk("empty", uv, 32'h0);
        // A low enable must hold the engine part way through its work
        wr(od, 8'h5C);
        ce <= 1'b0;
        repeat (6) @(posedge clk);
        ce <= 1'b1;
        rd(oi);
        chk("frozen", q[7], 32'h1);
        idle();
        $display("test fifo ended");
        conclude();
    end
endmodule
